/* File: mcuse_pkg.sv */
// Constants and types for the instruction subset execution unit
package mcuse_pkg;

  // Data path widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned TGT_W = 11;
  localparam int unsigned STACK_DEPTH = 8;

  // Register port offsets
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_UPPER_PC_LATCH = 8'h02;
  localparam logic [7:0] ADDR_PC_LO = 8'h03;
  localparam logic [7:0] ADDR_PC_HI = 8'h04;
  localparam logic [7:0] ADDR_STACK_TOP_LO = 8'h05;
  localparam logic [7:0] ADDR_STACK_TOP_HI = 8'h06;
  localparam logic [7:0] ADDR_WDT_COUNT = 8'h07;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_WDT_PRESCALE = 8'h09;
  // Offsets 0x80..0xff reach the file registers

  // Status register bit positions
  localparam int unsigned STATUS_Z_BIT = 2;
  localparam int unsigned STATUS_POWERDOWN_BIT = 3;
  localparam int unsigned STATUS_TIMEOUT_BIT = 4;
  // Control register bit positions
  localparam int unsigned CTRL_WDT_EN_BIT = 0;

  // Values after reset, and the last watchdog count
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic RST_Z = 1'b0;
  localparam logic RST_TIMEOUT_FLAG = 1'b1;
  localparam logic RST_POWERDOWN_FLAG = 1'b1;
  localparam logic RST_WDT_EN = 1'b0;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] WDT_LAST = 8'hff;

  // Operations carried out by this unit
  typedef enum logic [3:0] {
    op_nop,
    op_bit_test_skip_if_set,
    op_watchdog_clear,
    op_call,
    op_complement_file,
    op_clear_file,
    op_clear_accumulator,
    op_decrement_file,
    op_decrement_skip_zero
  } mcuse_op_t;

  // Issue slot state
  typedef enum logic {
    st_exec,
    st_flush
  } mcuse_state_t;

endpackage : mcuse_pkg

/* File: mcuse_stack.sv */
// Circular hardware return stack, push side and top of stack
`timescale 1ns/1ps
`default_nettype none
module mcuse_stack #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 13
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Push port
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  // Top of stack
  output logic [WIDTH-1:0] o_top
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_ff;
  logic [PTR_W-1:0] nxt_ptr;

  // Overflow wraps and overwrites the oldest entry, no error kept
  assign nxt_ptr = ptr_ff + PTR_W'(1);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr_ff <= '0;
    end else if (i_push) begin
      ptr_ff <= nxt_ptr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem[nxt_ptr] <= i_data;
    end
  end

  assign o_top = mem[ptr_ff];

endmodule : mcuse_stack
`default_nettype wire

/* File: mcuse_core.sv */
// Execution unit for a subset of an 8-bit instruction set
//
// Contract
// - Bit-test clear: next instruction executes normally
// - Bit-test set: next discarded, two cycles
// - Watchdog clear zeroes the watchdog counter
// - Watchdog clear also zeroes the prescaler
// - Watchdog clear sets timeout and powerdown flags
// - Call pushes PC plus one first
// - Call target low, latch bits 4:3 high
// - Call takes two instruction cycles
// - Complement file, result to accumulator or file
// - Clear file writes zero, sets zero flag
// - Clear accumulator writes zero, sets zero flag
// - Decrement file, result to accumulator or file
// - Decrement-skip stores result per destination bit
// - Zero result skips next, two cycles
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mcuse_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Instruction issue
  input wire logic i_op_valid,
  input wire mcuse_pkg::mcuse_op_t i_op,
  input wire logic [6:0] i_file_addr,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_dest,
  input wire logic [10:0] i_target,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // Execution status
  output logic [12:0] o_pc,
  output logic o_flush,
  output logic o_discard,
  output logic o_wdt_timeout
);

  // Architectural state
  logic [7:0] file_mem [128];
  logic [7:0] acc_ff;
  logic [7:0] latch_ff;
  logic [12:0] pc_ff;
  logic z_ff;
  logic timeout_flag_ff;
  logic powerdown_flag_ff;
  logic wdt_en_ff;
  logic [7:0] wdt_cnt_ff;
  logic [7:0] wdt_pre_ff;
  mcuse_pkg::mcuse_state_t state_ff;
  logic [7:0] rd_data_ff;
  logic discard_ff;
  logic timeout_ff;
  logic flush_ff;

  // Next values from the execute stage
  mcuse_pkg::mcuse_state_t nxt_state;
  logic [7:0] nxt_acc;
  logic nxt_z;
  logic [12:0] nxt_pc;
  logic nxt_acc_wr;
  logic nxt_z_wr;
  logic file_wr;
  logic [7:0] file_wdata;
  logic push;
  logic wdt_clear;

  logic exec;
  logic [7:0] file_q;
  logic [7:0] comp_val;
  logic [7:0] dec_val;
  logic [12:0] pc_inc;
  logic [12:0] stack_top;
  logic wdt_timeout;
  logic bus_file;
  logic [6:0] bus_faddr;

  assign exec = i_op_valid && (state_ff == mcuse_pkg::st_exec);
  assign file_q = file_mem[i_file_addr];
  assign comp_val = ~file_q;
  assign dec_val = file_q - 8'h01;
  assign pc_inc = pc_ff + 13'h0001;
  assign bus_file = i_addr[7];
  assign bus_faddr = i_addr[6:0];

  always_comb begin
    nxt_state = mcuse_pkg::st_exec;
    nxt_acc = acc_ff;
    nxt_acc_wr = 1'b0;
    nxt_z = z_ff;
    nxt_z_wr = 1'b0;
    nxt_pc = pc_ff;
    file_wr = 1'b0;
    file_wdata = file_q;
    push = 1'b0;
    wdt_clear = 1'b0;
    // Flush cycle holds the PC; the skipped slot was counted at issue
    if (exec) begin
      nxt_pc = pc_inc;
      case (i_op)
        mcuse_pkg::op_bit_test_skip_if_set: begin
          if (file_q[i_bit_sel]) begin
            nxt_pc = pc_ff + 13'h0002;
            nxt_state = mcuse_pkg::st_flush;
          end
        end
        mcuse_pkg::op_watchdog_clear: begin
          wdt_clear = 1'b1;
        end
        mcuse_pkg::op_call: begin
          push = 1'b1;
          nxt_pc = {latch_ff[4:3], i_target};
          nxt_state = mcuse_pkg::st_flush;
        end
        mcuse_pkg::op_complement_file: begin
          if (i_dest) begin
            file_wr = 1'b1;
            file_wdata = comp_val;
          end else begin
            nxt_acc_wr = 1'b1;
            nxt_acc = comp_val;
          end
          nxt_z_wr = 1'b1;
          nxt_z = (comp_val == 8'h00);
        end
        mcuse_pkg::op_clear_file: begin
          file_wr = 1'b1;
          file_wdata = 8'h00;
          nxt_z_wr = 1'b1;
          nxt_z = 1'b1;
        end
        mcuse_pkg::op_clear_accumulator: begin
          nxt_acc_wr = 1'b1;
          nxt_acc = 8'h00;
          nxt_z_wr = 1'b1;
          nxt_z = 1'b1;
        end
        mcuse_pkg::op_decrement_file: begin
          if (i_dest) begin
            file_wr = 1'b1;
            file_wdata = dec_val;
          end else begin
            nxt_acc_wr = 1'b1;
            nxt_acc = dec_val;
          end
          nxt_z_wr = 1'b1;
          nxt_z = (dec_val == 8'h00);
        end
        mcuse_pkg::op_decrement_skip_zero: begin
          if (i_dest) begin
            file_wr = 1'b1;
            file_wdata = dec_val;
          end else begin
            nxt_acc_wr = 1'b1;
            nxt_acc = dec_val;
          end
          if (dec_val == 8'h00) begin
            nxt_pc = pc_ff + 13'h0002;
            nxt_state = mcuse_pkg::st_flush;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Return stack
  mcuse_stack #(
    .DEPTH(mcuse_pkg::STACK_DEPTH),
    .WIDTH(mcuse_pkg::PC_W)
  ) u_stack (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_push(push),
    .i_data(pc_inc),
    .o_top(stack_top)
  );

  // Issue slot and program counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= mcuse_pkg::st_exec;
      pc_ff <= mcuse_pkg::RST_PC;
      flush_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      // Own flop so the flush output carries no decode
      flush_ff <= (nxt_state == mcuse_pkg::st_flush);
    end
  end

  // Discarded slot marker
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      discard_ff <= 1'b0;
    end else begin
      discard_ff <= i_op_valid && (state_ff == mcuse_pkg::st_flush);
    end
  end

  // Accumulator; instruction result beats a same-cycle bus write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc_ff <= mcuse_pkg::RST_ACC;
    end else if (nxt_acc_wr) begin
      acc_ff <= nxt_acc;
    end else if (i_wr && i_addr == mcuse_pkg::ADDR_ACC) begin
      acc_ff <= i_wr_data;
    end
  end

  // Upper PC latch and watchdog enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      latch_ff <= mcuse_pkg::RST_LATCH;
      wdt_en_ff <= mcuse_pkg::RST_WDT_EN;
    end else if (i_wr && i_addr == mcuse_pkg::ADDR_UPPER_PC_LATCH) begin
      latch_ff <= i_wr_data;
    end else if (i_wr && i_addr == mcuse_pkg::ADDR_CTRL) begin
      wdt_en_ff <= i_wr_data[mcuse_pkg::CTRL_WDT_EN_BIT];
    end
  end

  // Zero flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      z_ff <= mcuse_pkg::RST_Z;
    end else if (nxt_z_wr) begin
      z_ff <= nxt_z;
    end else if (i_wr && i_addr == mcuse_pkg::ADDR_STATUS) begin
      z_ff <= i_wr_data[mcuse_pkg::STATUS_Z_BIT];
    end
  end

  // Timeout and powerdown flags, active low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      timeout_flag_ff <= mcuse_pkg::RST_TIMEOUT_FLAG;
      powerdown_flag_ff <= mcuse_pkg::RST_POWERDOWN_FLAG;
    end else if (wdt_clear) begin
      timeout_flag_ff <= 1'b1;
      powerdown_flag_ff <= 1'b1;
    end else if (wdt_timeout) begin
      timeout_flag_ff <= 1'b0;
    end else if (i_wr && i_addr == mcuse_pkg::ADDR_STATUS) begin
      timeout_flag_ff <= i_wr_data[mcuse_pkg::STATUS_TIMEOUT_BIT];
      powerdown_flag_ff <= i_wr_data[mcuse_pkg::STATUS_POWERDOWN_BIT];
    end
  end

  // Watchdog prescaler and counter
  assign wdt_timeout = wdt_en_ff && (wdt_pre_ff == mcuse_pkg::WDT_LAST)
    && (wdt_cnt_ff == mcuse_pkg::WDT_LAST);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wdt_cnt_ff <= mcuse_pkg::WDT_CLEAR;
      wdt_pre_ff <= mcuse_pkg::WDT_CLEAR;
    end else if (wdt_clear) begin
      wdt_cnt_ff <= mcuse_pkg::WDT_CLEAR;
      wdt_pre_ff <= mcuse_pkg::WDT_CLEAR;
    end else if (wdt_en_ff) begin
      wdt_pre_ff <= wdt_pre_ff + 8'h01;
      if (wdt_pre_ff == mcuse_pkg::WDT_LAST) begin
        wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      timeout_ff <= 1'b0;
    end else begin
      timeout_ff <= wdt_timeout && !wdt_clear;
    end
  end

  // File registers: one write port, the instruction wins over the bus
  always_ff @(posedge i_clk) begin
    if (file_wr) begin
      file_mem[i_file_addr] <= file_wdata;
    end else if (i_wr && bus_file) begin
      file_mem[bus_faddr] <= i_wr_data;
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_data_ff <= 8'h00;
    end else if (!i_rd) begin
      rd_data_ff <= 8'h00;
    end else if (bus_file) begin
      rd_data_ff <= file_mem[bus_faddr];
    end else if (i_addr == mcuse_pkg::ADDR_ACC) begin
      rd_data_ff <= acc_ff;
    end else if (i_addr == mcuse_pkg::ADDR_STATUS) begin
      rd_data_ff <= {3'b000, timeout_flag_ff, powerdown_flag_ff, z_ff, 2'b00};
    end else if (i_addr == mcuse_pkg::ADDR_UPPER_PC_LATCH) begin
      rd_data_ff <= latch_ff;
    end else if (i_addr == mcuse_pkg::ADDR_PC_LO) begin
      rd_data_ff <= pc_ff[7:0];
    end else if (i_addr == mcuse_pkg::ADDR_PC_HI) begin
      rd_data_ff <= {3'b000, pc_ff[12:8]};
    end else if (i_addr == mcuse_pkg::ADDR_STACK_TOP_LO) begin
      rd_data_ff <= stack_top[7:0];
    end else if (i_addr == mcuse_pkg::ADDR_STACK_TOP_HI) begin
      rd_data_ff <= {3'b000, stack_top[12:8]};
    end else if (i_addr == mcuse_pkg::ADDR_WDT_COUNT) begin
      rd_data_ff <= wdt_cnt_ff;
    end else if (i_addr == mcuse_pkg::ADDR_WDT_PRESCALE) begin
      rd_data_ff <= wdt_pre_ff;
    end else if (i_addr == mcuse_pkg::ADDR_CTRL) begin
      rd_data_ff <= {7'b000_0000, wdt_en_ff};
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_pc = pc_ff;
  assign o_flush = flush_ff;
  assign o_discard = discard_ff;
  assign o_wdt_timeout = timeout_ff;

endmodule : mcuse_core
`default_nettype wire

/* File: mcuse_core_chk.sv */
// Port checker for the instruction subset execution unit
`timescale 1ns/1ps
`default_nettype none
module mcuse_core_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Instruction issue
  input wire logic i_op_valid,
  input wire mcuse_pkg::mcuse_op_t i_op,
  input wire logic [10:0] i_target,
  // Execution status
  input wire logic [12:0] o_pc,
  input wire logic o_flush,
  input wire logic o_discard,
  input wire logic o_wdt_timeout
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Instruction actually taken this cycle
  logic tk;
  assign tk = i_op_valid && !o_flush;

  call_flush_a: assert property (
    tk && i_op == mcuse_pkg::op_call |=> o_flush)
    else $error("call did not open a flush slot");
  call_target_a: assert property (
    tk && i_op == mcuse_pkg::op_call |=> o_pc[10:0] == $past(i_target))
    else $error("call target not loaded into pc");
  flush_once_a: assert property (
    o_flush |=> !o_flush)
    else $error("flush slot lasted more than one cycle");
  flush_pc_a: assert property (
    o_flush |=> $stable(o_pc))
    else $error("pc moved in a flush slot");
  drop_pulse_a: assert property (
    o_flush && i_op_valid |=> o_discard)
    else $error("dropped instruction not reported");
  no_drop_a: assert property (
    !(o_flush && i_op_valid) |=> !o_discard)
    else $error("discard pulse without a dropped instruction");
  plain_pc_a: assert property (
    tk && i_op inside {mcuse_pkg::op_complement_file,
      mcuse_pkg::op_clear_file, mcuse_pkg::op_clear_accumulator,
      mcuse_pkg::op_decrement_file, mcuse_pkg::op_watchdog_clear}
    |=> !o_flush && o_pc == $past(o_pc) + 13'h0001)
    else $error("single cycle operation did not advance pc by one");
  skip_pc_a: assert property (
    tk && i_op inside {mcuse_pkg::op_bit_test_skip_if_set,
      mcuse_pkg::op_decrement_skip_zero}
    |=> o_pc == $past(o_pc) + (o_flush ? 13'h0002 : 13'h0001))
    else $error("skip operation pc step wrong");
  wdt_clear_a: assert property (
    tk && i_op == mcuse_pkg::op_watchdog_clear |=> !o_wdt_timeout)
    else $error("timeout right after watchdog clear");

  call_c: cover property (tk && i_op == mcuse_pkg::op_call);
  skip_c: cover property (tk && i_op == mcuse_pkg::op_decrement_skip_zero
    ##1 o_flush);
  drop_c: cover property (o_discard);
  tmo_c: cover property (o_wdt_timeout);
endmodule : mcuse_core_chk

bind mcuse_core mcuse_core_chk i_mcuse_core_chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_op_valid(i_op_valid),
  .i_op(i_op),
  .i_target(i_target),
  .o_pc(o_pc),
  .o_flush(o_flush),
  .o_discard(o_discard),
  .o_wdt_timeout(o_wdt_timeout)
);
`default_nettype wire

/* File: tb_mcuse_core.sv */
// Self-checking bench for the instruction subset execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_mcuse_core;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_op_valid = 1'b0;
  mcuse_pkg::mcuse_op_t i_op = mcuse_pkg::op_nop;
  logic [6:0] i_file_addr = 7'h00;
  logic [2:0] i_bit_sel = 3'h0;
  logic i_dest = 1'b0;
  logic [10:0] i_target = 11'h000;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rd_data;
  logic [12:0] o_pc;
  logic o_flush;
  logic o_discard;
  logic o_wdt_timeout;
  int err_count = 0;
  int cmp_count = 0;
  logic [12:0] pc_m = 13'h0000;
  logic [12:0] top;
  localparam logic [7:0] ST = mcuse_pkg::ADDR_STATUS;
  localparam logic [7:0] AC = mcuse_pkg::ADDR_ACC;
  localparam int WDT_SPAN = (int'(mcuse_pkg::WDT_LAST) + 1)
    * (int'(mcuse_pkg::WDT_LAST) + 1);
  int wait_n = 0;

  always #12.5 i_clk = ~i_clk;

  mcuse_core i_mcuse_core (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_file_addr(i_file_addr), .i_bit_sel(i_bit_sel),
    .i_dest(i_dest), .i_target(i_target), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .o_pc(o_pc), .o_flush(o_flush),
    .o_discard(o_discard), .o_wdt_timeout(o_wdt_timeout)
  );

  task automatic chk(input string nm, input logic [12:0] e,
      input logic [12:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(nm, {5'h00, e}, {5'h00, o_rd_data});
  endtask : rd

  task automatic go(input mcuse_pkg::mcuse_op_t o, input logic [6:0] f,
      input logic [2:0] b, input logic d, input logic [10:0] t);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= o;
    i_file_addr <= f;
    i_bit_sel <= b;
    i_dest <= d;
    i_target <= t;
  endtask : go

  task automatic idle();
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    #1;
  endtask : idle

  task automatic op(input mcuse_pkg::mcuse_op_t o, input logic [6:0] f,
      input logic [2:0] b, input logic d, input logic sk);
    go(o, f, b, d, 11'h000);
    idle();
    pc_m = pc_m + (sk ? 13'h0002 : 13'h0001);
    chk("pc", pc_m, o_pc);
    chk("flush", {12'h000, sk}, {12'h000, o_flush});
  endtask : op

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (80000) @(posedge i_clk);
    err_count++;
    $display("[ERR] run expected done seen hang");
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(ST, 8'h18, "status");
    rd(8'h0a, 8'h00, "unmapped");
    wr(8'h85, 8'h5a);
    op(mcuse_pkg::op_clear_file, 7'h05, 3'h0, 1'b0, 1'b0);
    rd(8'h85, 8'h00, "file");
    rd(ST, 8'h1c, "status");
    wr(AC, 8'h33);
    wr(ST, 8'h18);
    op(mcuse_pkg::op_clear_accumulator, 7'h00, 3'h0, 1'b0, 1'b0);
    rd(AC, 8'h00, "acc");
    rd(ST, 8'h1c, "status");
    wr(8'h86, 8'h0f);
    op(mcuse_pkg::op_complement_file, 7'h06, 3'h0, 1'b0, 1'b0);
    rd(AC, 8'hf0, "acc");
    rd(8'h86, 8'h0f, "file");
    rd(ST, 8'h18, "status");
    wr(8'h86, 8'hff);
    op(mcuse_pkg::op_complement_file, 7'h06, 3'h0, 1'b1, 1'b0);
    rd(8'h86, 8'h00, "file");
    rd(ST, 8'h1c, "status");
    wr(8'h87, 8'h01);
    op(mcuse_pkg::op_decrement_file, 7'h07, 3'h0, 1'b0, 1'b0);
    rd(AC, 8'h00, "acc");
    rd(8'h87, 8'h01, "file");
    op(mcuse_pkg::op_decrement_file, 7'h07, 3'h0, 1'b1, 1'b0);
    op(mcuse_pkg::op_decrement_file, 7'h07, 3'h0, 1'b1, 1'b0);
    rd(8'h87, 8'hff, "file");
    rd(ST, 8'h18, "status");
    // Zero flag stays clear although the result reaches zero
    wr(8'h88, 8'h02);
    op(mcuse_pkg::op_decrement_skip_zero, 7'h08, 3'h0, 1'b1, 1'b0);
    rd(8'h88, 8'h01, "file");
    op(mcuse_pkg::op_decrement_skip_zero, 7'h08, 3'h0, 1'b1, 1'b1);
    rd(ST, 8'h18, "status");
    op(mcuse_pkg::op_decrement_skip_zero, 7'h08, 3'h0, 1'b0, 1'b0);
    rd(AC, 8'hff, "acc");
    rd(8'h88, 8'h00, "file");
    rd(ST, 8'h18, "status");
    wr(8'h89, 8'ha5);
    for (int b = 0; b < 8; b++) begin
      op(mcuse_pkg::op_bit_test_skip_if_set, 7'h09, 3'(b), 1'b0,
        1'(8'ha5 >> b));
    end
    // Instruction offered in the flush slot must be dropped
    go(mcuse_pkg::op_bit_test_skip_if_set, 7'h09, 3'h0, 1'b0, 11'h000);
    go(mcuse_pkg::op_clear_file, 7'h09, 3'h0, 1'b0, 11'h000);
    idle();
    pc_m = pc_m + 13'h0002;
    chk("pc", pc_m, o_pc);
    chk("discard", 13'h0001, {12'h000, o_discard});
    rd(8'h89, 8'ha5, "file");
    wr(mcuse_pkg::ADDR_CTRL, 8'h01);
    repeat (300) @(posedge i_clk);
    wr(mcuse_pkg::ADDR_CTRL, 8'h00);
    wr(ST, 8'h00);
    op(mcuse_pkg::op_watchdog_clear, 7'h00, 3'h0, 1'b0, 1'b0);
    rd(mcuse_pkg::ADDR_WDT_COUNT, 8'h00, "wdt");
    rd(mcuse_pkg::ADDR_WDT_PRESCALE, 8'h00, "prescale");
    rd(ST, 8'h18, "status");
    // Full span from a cleared watchdog, then a one-cycle pulse
    wr(mcuse_pkg::ADDR_CTRL, 8'h01);
    while (wait_n < 70000 && o_wdt_timeout !== 1'b1) begin
      @(posedge i_clk);
      #1;
      wait_n++;
    end
    cmp_count++;
    if (wait_n != WDT_SPAN) begin
      err_count++;
      $display("[ERR] wdt span expected %0d seen %0d", WDT_SPAN, wait_n);
    end
    @(posedge i_clk);
    #1;
    chk("timeout", 13'h0000, {12'h000, o_wdt_timeout});
    rd(ST, 8'h08, "status");
    wr(mcuse_pkg::ADDR_CTRL, 8'h00);
    wr(mcuse_pkg::ADDR_UPPER_PC_LATCH, 8'h18);
    top = pc_m + 13'h0001;
    go(mcuse_pkg::op_call, 7'h00, 3'h0, 1'b0, 11'h5a5);
    idle();
    pc_m = 13'h1da5;
    chk("pc", pc_m, o_pc);
    chk("flush", 13'h0001, {12'h000, o_flush});
    rd(8'h05, top[7:0], "top");
    rd(8'h06, {3'h0, top[12:8]}, "top");
    wr(mcuse_pkg::ADDR_UPPER_PC_LATCH, 8'h08);
    top = pc_m + 13'h0001;
    go(mcuse_pkg::op_call, 7'h00, 3'h0, 1'b0, 11'h123);
    go(mcuse_pkg::op_decrement_file, 7'h07, 3'h0, 1'b1, 11'h000);
    idle();
    chk("pc", 13'h0923, o_pc);
    chk("discard", 13'h0001, {12'h000, o_discard});
    rd(8'h87, 8'hff, "file");
    rd(8'h05, top[7:0], "top");
    rd(8'h06, {3'h0, top[12:8]}, "top");
    rd(ST, 8'h08, "status");
    give_verdict();
  end
endmodule : tb_mcuse_core
`default_nettype wire
